// File: inc/phsc_pkg.sv
/*
 * Shared constants and types for the power-host serial control block.
 * Assumes a single 25 MHz system clock; all pins arrive asynchronously.
 */
package phsc_pkg;

	localparam int CLK_PERIOD_NS = 40;
	// Interrupt pulse width; the figure is a plain default, adjust per system
	localparam int T_INT_NS      = 1000;
	localparam int INT_CYCLES    = (T_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_CNT_W     = 5;

	// Command field codes (upper three bits of a command byte)
	localparam logic [2:0] CMD_POWER_OFF = 3'h1;
	localparam logic [2:0] CMD_RAM_RD    = 3'h2;
	localparam logic [2:0] CMD_CSR_RD    = 3'h3;
	localparam logic [2:0] CMD_RAM_WR    = 3'h4;
	localparam logic [2:0] CMD_CSR_WR    = 3'h5;
	localparam logic [2:0] CMD_START_CHG = 3'h6;
	localparam logic [2:0] CMD_ABORT_CHG = 3'h7;

	localparam int CSR_BYTES   = 17;
	localparam int RAM_BYTES   = 32;
	localparam int CSR_SPARE_N = 14;

	localparam logic [4:0] ADDR_STATUS   = 5'h00;
	localparam logic [4:0] ADDR_MASK     = 5'h01;
	localparam logic [4:0] ADDR_OUT_CTL  = 5'h02;
	localparam logic [4:0] ADDR_SPARE0   = 5'h03;
	localparam logic [4:0] ADDR_LAST_CSR = 5'h10;

	localparam logic [7:0] MASK_RESET    = 8'h00;
	localparam logic [7:0] OUT_CTL_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam logic [2:0] BIT_LAST      = 3'h7;
	localparam int         PO_LAST       = 6;

	// Status register bit positions
	localparam int ST_IRQ = 0;
	localparam int ST_PSW = 7;

	typedef struct packed {
		logic psw;
		logic fault;
		logic gauge;
		logic dc_valid;
		logic backup_low;
		logic end_dis;
		logic charging;
		logic irq;
	} phsc_status_s;

	typedef struct packed {
		logic [2:0] op;
		logic [4:0] addr;
	} phsc_cmd_s;

	typedef struct packed {
		logic ds_n;
		logic ps_n;
		logic rs;
		logic dq;
		logic vcc_ok;
		logic dc_ok;
		logic end_discharge_flag;
		logic bkl;
		logic gauge_notify_flag;
		logic fault;
		logic done;
	} phsc_pins_s;

	localparam int         SYNC_W   = 11;
	// Strobe and switch idle high, so they leave reset high
	localparam logic [10:0] SYNC_RST = 11'h600;

	typedef enum {PSW_OFF, PSW_STOP, PSW_ON} phsc_psw_e;

endpackage

// File: rtl/phsc_sync.sv
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; no bus coherence is given.
 */
`timescale 1ns/1ps
module phsc_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= RST;
			sync_q <= RST;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule // phsc_sync

// File: rtl/phsc_pulse.sv
/*
 * Fixed-width active-low pulse generator for the interrupt line.
 * Assumes a fire request is a one-cycle pulse; a new one restarts the width.
 */
`timescale 1ns/1ps
module phsc_pulse
	import phsc_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_fire,
	output logic      o_low_n
);
	logic [INT_CNT_W-1:0] cnt_q;
	logic [INT_CNT_W-1:0] cnt_d;
	logic                 low_n_q;

	always_comb begin
		cnt_d = cnt_q;
		if (i_fire) begin
			cnt_d = INT_CYCLES[INT_CNT_W-1:0];
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q   <= '0;
			low_n_q <= 1'b1;
		end else begin
			cnt_q   <= cnt_d;
			low_n_q <= (cnt_d == '0);
		end
	end

	assign o_low_n = low_n_q;
endmodule // phsc_pulse

// File: rtl/phsc_top.sv
/*
 * Serial host port, power-switch sequencing, charge gating and seven
 * open-drain programmable outputs of a battery energy-management device.
 * Assumes every pin is asynchronous to I_SYS_CLK and slow against it.
 */
// How it works
// - Switch input low with switch control inactive activates switch control.
// - Switch input low stops charging before switch control goes active.
// - Switch input low leads to status bit 7 reading one.
// - Switch input low fires a fixed-width low interrupt pulse.
// - Only the power-off command releases switch control.
// - With switch control active, charging starts only by command.
// - With switch control inactive, a new charge supply may start charging.
// - Status bit 7 always mirrors switch control state.
// - Mask bit k (k from 0 to 5) set makes output k+1 show status bit k+1.
// - Mask bit k clear makes output k+1 show output-control bit k.
// - Output seven follows output-control bit 6 while mask bit 6 is clear.
// - Serial port answers only while main supply is valid.
// - Commands reach 17 control/status bytes and 32 storage bytes.
// - Three immediate commands plus four address-carrying access commands.
// - Field 011 reads, 101 writes a control/status byte.
// - Field 010 reads, 100 writes a storage byte.
// - One bit per strobe; select level marks command or data byte.
// - Strobe captures write bits and shifts read bits out.
// - Written bytes commit only after their eighth bit.
// - Interrupt flag sets whenever the interrupt line goes active.
// - Interrupt causes: switch low, gauge notice rising, end-of-discharge rising.
// - Write data is sampled at the strobe's rising edge.
// - Select low at strobe start abandons a partial data byte for a command.
// - Data bytes act on the latest command byte, and do nothing after an immediate one.
// - Data driver is released after the strobe rises.
`timescale 1ns/1ps
module phsc_top
	import phsc_pkg::*;
(
	input  wire logic       I_SYS_CLK,
	input  wire logic       I_RESETN,
	input  wire logic       I_DATA_STROBE_IN_N,
	input  wire logic       I_BYTE_SELECT_IN,
	input  wire logic       I_DQ,
	output logic            O_DQ,
	output logic            O_DQ_OE,
	output logic            O_IRQ_N,
	input  wire logic       I_POWER_SWITCH_IN_N,
	output logic            O_POWER_SWITCH_CTL_OUT_OE,
	output logic [6:0]      O_PROG_OUT_OE,
	input  wire logic       I_SUPPLY_VALID,
	input  wire logic       I_CHARGE_SUPPLY_IN,
	input  wire logic       I_END_DISCHARGE_FLAG,
	input  wire logic       I_BACKUP_LOW,
	input  wire logic       I_GAUGE_NOTIFY_FLAG,
	input  wire logic       I_BATTERY_FAULT,
	input  wire logic       I_CHARGE_DONE,
	output logic            O_CHARGE_ACTIVE
);
	localparam int IRQ_LEN = INT_CYCLES;

	phsc_pins_s   pins_a;
	phsc_pins_s   pins_s;
	phsc_pins_s   prev_q;
	phsc_status_s st_w;
	phsc_cmd_s    cmd_q;
	phsc_psw_e    psw_q;

	logic       ds_fall, ds_rise, ps_fall, dc_rise, ggn_rise, edv_rise;
	logic       irq_fire, irq_flag_q, psw_on_q, charge_q;
	logic [2:0] bit_cnt_q;
	logic       is_cmd_q;
	logic [7:0] shift_q, wbyte, rd_src, rd_byte_q;
	logic       dq_q, dq_oe_q, data_now;
	logic       byte_done, cmd_done, data_wr, st_read;
	logic [7:0] mask_q, out_ctl_q;
	logic [7:0] csr_spare_q [CSR_SPARE_N];
	logic [7:0] ram_q [RAM_BYTES];
	logic [6:0] po_oe_q;
	logic       chg_start_ok;

	function automatic logic is_spare(input logic [4:0] a);
		return (a >= ADDR_SPARE0) && (a <= ADDR_LAST_CSR);
	endfunction

	function automatic logic [3:0] spare_idx(input logic [4:0] a);
		logic [4:0] d;
		d = a - ADDR_SPARE0;
		return d[3:0];
	endfunction

	assign pins_a = '{ds_n: I_DATA_STROBE_IN_N, ps_n: I_POWER_SWITCH_IN_N,
		rs: I_BYTE_SELECT_IN, dq: I_DQ, vcc_ok: I_SUPPLY_VALID,
		dc_ok: I_CHARGE_SUPPLY_IN, end_discharge_flag: I_END_DISCHARGE_FLAG, bkl: I_BACKUP_LOW,
		gauge_notify_flag: I_GAUGE_NOTIFY_FLAG, fault: I_BATTERY_FAULT, done: I_CHARGE_DONE};

	phsc_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
		.i_clk   (I_SYS_CLK),
		.i_rst_n (I_RESETN),
		.i_async (pins_a),
		.o_sync  (pins_s)
	);

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			prev_q <= SYNC_RST;
		end else begin
			prev_q <= pins_s;
		end
	end

	assign ds_fall  = prev_q.ds_n & ~pins_s.ds_n;
	assign ds_rise  = ~prev_q.ds_n & pins_s.ds_n;
	assign ps_fall  = prev_q.ps_n & ~pins_s.ps_n;
	assign dc_rise  = ~prev_q.dc_ok & pins_s.dc_ok;
	assign ggn_rise = ~prev_q.gauge_notify_flag & pins_s.gauge_notify_flag;
	assign edv_rise = ~prev_q.end_discharge_flag & pins_s.end_discharge_flag;

	assign irq_fire = ps_fall | ggn_rise | edv_rise;

	phsc_pulse u_irq (
		.i_clk   (I_SYS_CLK),
		.i_rst_n (I_RESETN),
		.i_fire  (irq_fire),
		.o_low_n (O_IRQ_N)
	);

	assign st_w = '{psw: psw_on_q, fault: pins_s.fault, gauge: pins_s.gauge_notify_flag,
		dc_valid: pins_s.dc_ok, backup_low: pins_s.bkl, end_dis: pins_s.end_discharge_flag,
		charging: charge_q, irq: irq_flag_q};

	// Serial framing: the byte type is fixed by select at the first strobe
	assign data_now  = pins_s.rs & ((bit_cnt_q == '0) | ~is_cmd_q);
	assign byte_done = pins_s.vcc_ok & ds_rise & (bit_cnt_q == BIT_LAST);
	assign wbyte     = {pins_s.dq, shift_q[6:0]};
	assign cmd_done  = byte_done & is_cmd_q;
	assign data_wr   = byte_done & ~is_cmd_q &
		((cmd_q.op == CMD_CSR_WR) | (cmd_q.op == CMD_RAM_WR));
	assign st_read   = byte_done & ~is_cmd_q & (cmd_q.op == CMD_CSR_RD) &
		(cmd_q.addr == ADDR_STATUS);

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			bit_cnt_q <= '0;
			is_cmd_q  <= 1'b1;
		end else if (!pins_s.vcc_ok) begin
			bit_cnt_q <= '0;
			is_cmd_q  <= 1'b1;
		end else if (ds_fall) begin
			if (!pins_s.rs) begin
				if (!is_cmd_q) begin
					bit_cnt_q <= '0;
				end
				is_cmd_q <= 1'b1;
			end else if (bit_cnt_q == '0) begin
				is_cmd_q <= 1'b0;
			end
		end else if (ds_rise) begin
			bit_cnt_q <= bit_cnt_q + 1'b1;
		end
	end

	// Capture on the strobe's rising edge; both pins share the same sync delay
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			shift_q <= BYTE_ZERO;
		end else if (pins_s.vcc_ok && ds_rise) begin
			shift_q[bit_cnt_q] <= pins_s.dq;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cmd_q <= '0;
		end else if (cmd_done) begin
			cmd_q <= wbyte;
		end
	end

	// Read source; status is captured at byte start so a byte stays coherent
	always_comb begin
		rd_src = BYTE_ZERO;
		if (cmd_q.op == CMD_CSR_RD) begin
			if (cmd_q.addr == ADDR_STATUS) begin
				rd_src = st_w;
			end else if (cmd_q.addr == ADDR_MASK) begin
				rd_src = mask_q;
			end else if (cmd_q.addr == ADDR_OUT_CTL) begin
				rd_src = out_ctl_q;
			end else if (is_spare(cmd_q.addr)) begin
				rd_src = csr_spare_q[spare_idx(cmd_q.addr)];
			end
		end else if (cmd_q.op == CMD_RAM_RD) begin
			rd_src = ram_q[cmd_q.addr];
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rd_byte_q <= BYTE_ZERO;
			dq_q      <= 1'b0;
			dq_oe_q   <= 1'b0;
		end else if (!pins_s.vcc_ok) begin
			dq_oe_q <= 1'b0;
		end else if (ds_fall && data_now &&
			((cmd_q.op == CMD_CSR_RD) || (cmd_q.op == CMD_RAM_RD))) begin
			dq_oe_q <= 1'b1;
			if (bit_cnt_q == '0) begin
				rd_byte_q <= rd_src;
				dq_q      <= rd_src[0];
			end else begin
				dq_q <= rd_byte_q[bit_cnt_q];
			end
		end else if (ds_rise) begin
			dq_oe_q <= 1'b0;
		end
	end

	// Register and storage writes, taken only on a whole byte
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			mask_q    <= MASK_RESET;
			out_ctl_q <= OUT_CTL_RESET;
			for (int i = 0; i < CSR_SPARE_N; i++) begin
				csr_spare_q[i] <= BYTE_ZERO;
			end
		end else if (data_wr && (cmd_q.op == CMD_CSR_WR)) begin
			if (cmd_q.addr == ADDR_MASK) begin
				mask_q <= wbyte;
			end else if (cmd_q.addr == ADDR_OUT_CTL) begin
				out_ctl_q <= wbyte;
			end else if (is_spare(cmd_q.addr)) begin
				csr_spare_q[spare_idx(cmd_q.addr)] <= wbyte;
			end
		end
	end

	// Storage bytes keep their contents across reset
	always_ff @(posedge I_SYS_CLK) begin
		if (data_wr && (cmd_q.op == CMD_RAM_WR)) begin
			ram_q[cmd_q.addr] <= wbyte;
		end
	end

	// Interrupt flag: reading the status byte clears it, a new event wins
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			irq_flag_q <= 1'b0;
		end else if (irq_fire) begin
			irq_flag_q <= 1'b1;
		end else if (st_read) begin
			irq_flag_q <= 1'b0;
		end
	end

	// Switch sequencing passes through a stop state so charging ends first
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			psw_q    <= PSW_OFF;
			psw_on_q <= 1'b0;
		end else begin
			case (psw_q)
				PSW_OFF: begin
					if (ps_fall) begin
						psw_q <= PSW_STOP;
					end
				end
				PSW_STOP: begin
					if (!charge_q) begin
						psw_q    <= PSW_ON;
						psw_on_q <= 1'b1;
					end
				end
				PSW_ON: begin
					if (cmd_done && (wbyte[7:5] == CMD_POWER_OFF)) begin
						psw_q    <= PSW_OFF;
						psw_on_q <= 1'b0;
					end
				end
				default: begin
					psw_q    <= PSW_OFF;
					psw_on_q <= 1'b0;
				end
			endcase
		end
	end

	assign chg_start_ok = pins_s.dc_ok & ~pins_s.fault;

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			charge_q <= 1'b0;
		end else if (ps_fall || (psw_q == PSW_STOP)) begin
			charge_q <= 1'b0;
		end else if (cmd_done && (wbyte[7:5] == CMD_ABORT_CHG)) begin
			charge_q <= 1'b0;
		end else if (pins_s.done || !chg_start_ok) begin
			charge_q <= 1'b0;
		end else if (psw_on_q) begin
			if (cmd_done && (wbyte[7:5] == CMD_START_CHG)) begin
				charge_q <= 1'b1;
			end
		end else if (psw_q == PSW_OFF && dc_rise) begin
			charge_q <= 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			po_oe_q <= '0;
		end else begin
			for (int k = 0; k < PO_LAST; k++) begin
				po_oe_q[k] <= mask_q[k] ? st_w[k+1] : out_ctl_q[k];
			end
			// With its mask bit set, output seven has no status source and floats
			po_oe_q[PO_LAST] <= ~mask_q[PO_LAST] & out_ctl_q[PO_LAST];
		end
	end

	assign O_DQ                      = dq_q;
	assign O_DQ_OE                   = dq_oe_q;
	assign O_POWER_SWITCH_CTL_OUT_OE = psw_on_q;
	assign O_PROG_OUT_OE             = po_oe_q;
	assign O_CHARGE_ACTIVE           = charge_q;

	logic [7:0] irq_low_cnt_q;
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			irq_low_cnt_q <= '0;
		end else if (O_IRQ_N) begin
			irq_low_cnt_q <= '0;
		end else if (irq_low_cnt_q != 8'hFF) begin
			irq_low_cnt_q <= irq_low_cnt_q + 1'b1;
		end
	end

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESETN);

	property p_psw_seq;
		(ps_fall && psw_q == PSW_OFF) |=> !charge_q ##1 O_POWER_SWITCH_CTL_OUT_OE;
	endproperty
	a_psw_seq: assert property (p_psw_seq) else $error("switch control not sequenced");

	property p_psw_flag;
		st_w[ST_PSW] == (psw_q == PSW_ON);
	endproperty
	a_psw_flag: assert property (p_psw_flag) else $error("status bit 7 wrong");

	property p_irq_width;
		$rose(O_IRQ_N) |-> irq_low_cnt_q >= IRQ_LEN;
	endproperty
	a_irq_width: assert property (p_irq_width) else $error("interrupt pulse too short");

	property p_irq_start;
		irq_fire |=> !O_IRQ_N && irq_flag_q;
	endproperty
	a_irq_start: assert property (p_irq_start) else $error("interrupt not raised");

	property p_psw_hold;
		$fell(O_POWER_SWITCH_CTL_OUT_OE) |-> $past(cmd_done && wbyte[7:5] == CMD_POWER_OFF);
	endproperty
	a_psw_hold: assert property (p_psw_hold) else $error("switch released without command");

	property p_chg_cmd;
		($rose(charge_q) && $past(psw_on_q)) |-> $past(cmd_done && wbyte[7:5] == CMD_START_CHG);
	endproperty
	a_chg_cmd: assert property (p_chg_cmd) else $error("charge started without command");

	property p_dc_start;
		(psw_q == PSW_OFF && dc_rise && !ps_fall && !cmd_done && !pins_s.done
			&& !pins_s.fault) |=> charge_q;
	endproperty
	a_dc_start: assert property (p_dc_start) else $error("supply did not start charge");

	property p_po1;
		##1 O_PROG_OUT_OE[0] == $past(mask_q[0] ? st_w[1] : out_ctl_q[0]);
	endproperty
	a_po1: assert property (p_po1) else $error("output one source wrong");

	property p_po7;
		!mask_q[PO_LAST] ##1 !$past(mask_q[PO_LAST]) |-> O_PROG_OUT_OE[PO_LAST] == $past(out_ctl_q[PO_LAST]);
	endproperty
	a_po7: assert property (p_po7) else $error("output seven source wrong");

	property p_quiet;
		!pins_s.vcc_ok |=> !O_DQ_OE && bit_cnt_q == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("port active without supply");

	property p_release;
		ds_rise |=> !O_DQ_OE;
	endproperty
	a_release: assert property (p_release) else $error("data driver not released");

	property p_resync;
		(pins_s.vcc_ok && ds_fall && !pins_s.rs && !is_cmd_q) |=> bit_cnt_q == '0 && is_cmd_q;
	endproperty
	a_resync: assert property (p_resync) else $error("partial byte not abandoned");

	property p_commit;
		(mask_q != $past(mask_q)) |-> $past(byte_done);
	endproperty
	a_commit: assert property (p_commit) else $error("mask changed mid byte");

	c_power_on: cover property (ps_fall ##[1:4] O_POWER_SWITCH_CTL_OUT_OE);
	c_mask_wr:  cover property (data_wr && cmd_q.op == CMD_CSR_WR && cmd_q.addr == ADDR_MASK);
	c_ram_rd:   cover property (byte_done && !is_cmd_q && cmd_q.op == CMD_RAM_RD);
	c_st_clear: cover property (st_read && irq_flag_q);
endmodule // phsc_top

// File: tb/phsc_host.sv
/* Host model for the three-pin serial port: strobe, select and data line.
   Assumes the bench calls xfer from one process and owns all other pins. */
`timescale 1ns/1ps
module phsc_host (
	input  wire logic i_clk,
	input  wire logic i_dev_dq,
	input  wire logic i_dev_oe,
	output logic      o_strobe_n,
	output logic      o_select,
	output logic      o_dq
);
	// Four clocks a phase gives a 320 ns strobe period; enough for sync plus edge detect
	localparam int PHASE = 4;
	logic drv    = 1'b0;
	logic bit_v  = 1'b0;
	logic last_q = 1'b0;
	initial begin
		o_strobe_n = 1'b1;
		o_select   = 1'b0;
	end
	// Released line shows the inverse of its last level, so stale data cannot match
	always_comb o_dq = i_dev_oe ? i_dev_dq : (drv ? bit_v : ~last_q);
	// Only driven levels are remembered, so a released line holds still
	always @(posedge i_clk) if (i_dev_oe || drv) last_q <= o_dq;
	// Strobe rests high outside an intended access
	task automatic xfer(input logic sel, input logic wr, input logic [7:0] wd,
			input int nbits, output logic [7:0] rd);
		rd = 8'h00;
		for (int i = 0; i < nbits; i++) begin // LSB first
			@(negedge i_clk);
			o_select   = sel;
			drv        = wr;
			bit_v      = wd[i];
			o_strobe_n = 1'b0;
			repeat (PHASE) @(negedge i_clk);
			rd[i]      = o_dq;
			o_strobe_n = 1'b1; // Data held past the rise
			// The next bit's own edge wait completes the high phase
			repeat (PHASE - 1) @(negedge i_clk);
		end
		drv = 1'b0;
	endtask
endmodule // phsc_host

// File: tb/tb_phsc_top.sv
/* Self-checking bench for phsc_top, with a host model on the serial port.
   Assumes the package constants; storage bytes are read only after writing. */
`timescale 1ns/1ps
module tb_phsc_top;
	import phsc_pkg::*;
	logic       clk   = 1'b0;
	logic       rst_n = 1'b0;
	logic       ds_n, sel, dq_w, dq_o, dq_oe, irq_n, psc_oe, chg;
	logic [6:0] prog_oe;
	logic       psw_n = 1'b1;
	logic       vcc   = 1'b1;
	logic       dc    = 1'b0;
	logic       end_discharge_flag   = 1'b0;
	logic       bkl   = 1'b0;
	logic       gauge_notify_flag   = 1'b0;
	logic       flt   = 1'b0;
	logic       done  = 1'b0;
	int         fail_count = 0;
	int         n_compared = 0;
	int         lows;
	logic       c_at;
	logic [7:0] d;

	always #20 clk = ~clk;

	phsc_host i_phsc_host (.i_clk(clk), .i_dev_dq(dq_o), .i_dev_oe(dq_oe),
		.o_strobe_n(ds_n), .o_select(sel), .o_dq(dq_w));

	phsc_top i_phsc_top (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_DATA_STROBE_IN_N(ds_n),
		.I_BYTE_SELECT_IN(sel), .I_DQ(dq_w), .O_DQ(dq_o), .O_DQ_OE(dq_oe), .O_IRQ_N(irq_n),
		.I_POWER_SWITCH_IN_N(psw_n), .O_POWER_SWITCH_CTL_OUT_OE(psc_oe),
		.O_PROG_OUT_OE(prog_oe), .I_SUPPLY_VALID(vcc), .I_CHARGE_SUPPLY_IN(dc),
		.I_END_DISCHARGE_FLAG(end_discharge_flag), .I_BACKUP_LOW(bkl), .I_GAUGE_NOTIFY_FLAG(gauge_notify_flag),
		.I_BATTERY_FAULT(flt), .I_CHARGE_DONE(done), .O_CHARGE_ACTIVE(chg));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic cmd(input logic [2:0] op, input logic [4:0] a);
		logic [7:0] r;
		i_phsc_host.xfer(1'b0, 1'b1, {op, a}, 8, r);
	endtask

	task automatic wr(input logic [2:0] op, input logic [4:0] a, input logic [7:0] v);
		logic [7:0] r;
		cmd(op, a);
		i_phsc_host.xfer(1'b1, 1'b1, v, 8, r);
	endtask

	task automatic rd(input logic [2:0] op, input logic [4:0] a, output logic [7:0] v);
		cmd(op, a);
		i_phsc_host.xfer(1'b1, 1'b0, 8'h00, 8, v);
	endtask

	// Fixed window long enough for a whole pulse; notes charge when switch control rises
	task automatic watch(output int n, output logic c);
		logic prev;
		prev = psc_oe;
		n    = 0;
		c    = 1'bx;
		repeat (40) begin
			@(negedge clk);
			if (irq_n === 1'b0)
				n++;
			if (psc_oe === 1'b1 && prev !== 1'b1)
				c = chg;
			prev = psc_oe;
		end
	endtask

	task automatic t_outputs();
		check({4'h0, dq_oe, irq_n, psc_oe, chg}, 8'h04);
		check({1'b0, prog_oe}, 8'h00);
		wr(CMD_CSR_WR, ADDR_MASK, 8'h00);
		wr(CMD_CSR_WR, ADDR_OUT_CTL, 8'h55);
		cyc(4);
		check({1'b0, prog_oe}, 8'h55);
		flt = 1'b1;
		end_discharge_flag = 1'b1;
		bkl = 1'b1;
		cyc(8);
		dc = 1'b1;
		wr(CMD_CSR_WR, ADDR_OUT_CTL, 8'h50);
		wr(CMD_CSR_WR, ADDR_MASK, 8'h0F);
		cyc(4);
		check({1'b0, prog_oe}, 8'h5E);
		wr(CMD_CSR_WR, ADDR_MASK, 8'h7F);
		cyc(4);
		check({1'b0, prog_oe}, 8'h2E);
		rd(CMD_CSR_RD, ADDR_MASK, d);
		check(d, 8'h7F);
		dc  = 1'b0;
		flt = 1'b0;
		end_discharge_flag = 1'b0;
		bkl = 1'b0;
		cyc(8);
		check({1'b0, prog_oe}, 8'h00);
		wr(CMD_CSR_WR, ADDR_MASK, MASK_RESET);
		$display("test outputs done");
	endtask

	task automatic t_storage();
		wr(CMD_CSR_WR, ADDR_SPARE0, 8'hA5);
		wr(CMD_CSR_WR, ADDR_LAST_CSR, 8'h3C);
		wr(CMD_RAM_WR, 5'h1F, 8'hC3);
		wr(CMD_RAM_WR, 5'h00, 8'h81);
		rd(CMD_CSR_RD, ADDR_SPARE0, d);
		check(d, 8'hA5);
		i_phsc_host.xfer(1'b1, 1'b0, 8'h00, 8, d);
		check(d, 8'hA5);
		check({7'h00, dq_oe}, 8'h00);
		rd(CMD_CSR_RD, ADDR_LAST_CSR, d);
		check(d, 8'h3C);
		rd(CMD_CSR_RD, 5'h11, d);
		check(d, 8'h00);
		rd(CMD_RAM_RD, 5'h1F, d);
		check(d, 8'hC3);
		rd(CMD_RAM_RD, 5'h00, d);
		check(d, 8'h81);
		$display("test storage done");
	endtask

	// Partial byte, then writes with the supply flagged bad: neither may land
	task automatic t_abort();
		cmd(CMD_CSR_WR, ADDR_SPARE0);
		i_phsc_host.xfer(1'b1, 1'b1, 8'h00, 3, d);
		rd(CMD_CSR_RD, ADDR_SPARE0, d);
		check(d, 8'hA5);
		vcc = 1'b0;
		wr(CMD_CSR_WR, ADDR_SPARE0, 8'h11);
		vcc = 1'b1;
		cyc(4);
		rd(CMD_CSR_RD, ADDR_SPARE0, d);
		check(d, 8'hA5);
		$display("test abort done");
	endtask

	task automatic t_power();
		dc = 1'b1;
		cyc(8);
		check({7'h00, chg}, 8'h01);
		psw_n = 1'b0;
		watch(lows, c_at);
		check({7'h00, c_at}, 8'h00);
		check(8'(lows), 8'(INT_CYCLES));
		check({7'h00, psc_oe}, 8'h01);
		psw_n = 1'b1;
		rd(CMD_CSR_RD, ADDR_STATUS, d);
		check(d & 8'h81, 8'h81);
		dc = 1'b0;
		cyc(8);
		dc = 1'b1;
		cyc(8);
		check({7'h00, chg}, 8'h00);
		cmd(CMD_START_CHG, 5'h00);
		cyc(4);
		check({7'h00, chg}, 8'h01);
		cmd(CMD_ABORT_CHG, 5'h00);
		cyc(4);
		check({7'h00, chg}, 8'h00);
		psw_n = 1'b0;
		watch(lows, c_at);
		check({7'h00, psc_oe}, 8'h01);
		check(8'(lows), 8'(INT_CYCLES));
		psw_n = 1'b1;
		cmd(CMD_POWER_OFF, 5'h00);
		cyc(4);
		check({7'h00, psc_oe}, 8'h00);
		rd(CMD_CSR_RD, ADDR_STATUS, d);
		check(d & 8'h80, 8'h00);
		dc = 1'b0;
		cyc(8);
		dc = 1'b1;
		cyc(8);
		check({7'h00, chg}, 8'h01);
		done = 1'b1;
		cyc(8);
		check({7'h00, chg}, 8'h00);
		done = 1'b0;
		dc   = 1'b0;
		$display("test power done");
	endtask

	task automatic t_causes();
		gauge_notify_flag = 1'b1;
		watch(lows, c_at);
		check(8'(lows), 8'(INT_CYCLES));
		gauge_notify_flag = 1'b0;
		end_discharge_flag = 1'b1;
		watch(lows, c_at);
		check(8'(lows), 8'(INT_CYCLES));
		rd(CMD_CSR_RD, ADDR_STATUS, d);
		check(d & 8'h05, 8'h05);
		end_discharge_flag = 1'b0;
		$display("test causes done");
	endtask

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		cyc(4);
		t_outputs();
		t_storage();
		t_abort();
		t_power();
		t_causes();
		print_verdict();
	end

	// Cuts a hang short at 100000 cycles, far above what the tests need
	initial begin
		#4000000;
		fail_count++;
		print_verdict();
	end
endmodule // tb_phsc_top
